// ### src/iplr_level_field.sv
// iplr_level_field: one 3-bit priority field with its decode
// assumes write strobe comes from the apb access phase in the same clock domain
`timescale 1ns/1ps
module iplr_level_field (
    // clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // software write
    input wire logic wrEn,
    input wire logic [2:0] wrData,
    // decoded outputs
    output logic [2:0] level,
    output logic enabled
);
    import iplr_pkg::*;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            level <= IPLR_LEVEL_RESET; // [RQ6]
        end else if (wrEn) begin
            level <= wrData;
        end
    end

    // linear code: 7 highest, 1 lowest, 0 blocks the source
    assign enabled = (level != IPLR_LEVEL_OFF); // [RQ1] [RQ2]
endmodule

// ### src/iplr_pkg.sv
// iplr_pkg: register map, field layout and reset values of the priority register bank
// assumes a 32-bit apb slave with one aligned word per register
package iplr_pkg;

    // ------------------------------------------------------------
    // register byte addresses
    // ------------------------------------------------------------
    localparam logic [11:0] IPLR_OFS_I2C_EVENTS = 12'h000;
    localparam logic [11:0] IPLR_OFS_EXT_IRQ1 = 12'h004;
    localparam logic [11:0] IPLR_OFS_TIMER4_COMPARE3 = 12'h008;

    // ------------------------------------------------------------
    // field positions (lsb of each 3-bit field)
    // ------------------------------------------------------------
    localparam int IPLR_LEVEL_W = 3;
    localparam int IPLR_POS_I2C_TARGET = 0;
    localparam int IPLR_POS_EXT_IRQ1 = 0;
    localparam int IPLR_POS_TIMER4 = 12;
    localparam int IPLR_POS_COMPARE3 = 4;

    // ------------------------------------------------------------
    // reset and special codes
    // ------------------------------------------------------------
    localparam logic [2:0] IPLR_LEVEL_RESET = 3'h4;
    localparam logic [2:0] IPLR_LEVEL_OFF = 3'h0;

    typedef struct packed {
        logic [2:0] i2cTargetEvent;
        logic [2:0] extIrq1;
        logic [2:0] timer4;
        logic [2:0] compare3;
    } iplr_levels_t;

    typedef struct packed {
        logic i2cTargetEvent;
        logic extIrq1;
        logic timer4;
        logic compare3;
    } iplr_enables_t;

endpackage

// ### src/iplr_regs.sv
// iplr_regs: apb-reachable bank of interrupt priority level registers
// assumes a single clock domain; the arbiter consuming the levels sits elsewhere
//
// Operation
// RQ1: field code maps linearly, 7 highest, 1 lowest
// RQ2: code zero disables its interrupt source
// RQ3: unimplemented register bits read back zero
// RQ4: external interrupt 1 level in bits 2:0
// RQ5: timer4 bits 14:12, compare3 bits 6:4
// RQ6: all fields reset to level 4
//
// Local design decisions: the APB register port and the register offsets.
`timescale 1ns/1ps
module iplr_regs (
    // clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // levels to the arbiter
    output iplr_pkg::iplr_levels_t levels,
    output iplr_pkg::iplr_enables_t enables
);
    import iplr_pkg::*;

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    wire logic setupPhase = psel && !penable;
    wire logic hitI2c = (paddr == IPLR_OFS_I2C_EVENTS);
    wire logic hitExt = (paddr == IPLR_OFS_EXT_IRQ1);
    wire logic hitTmr = (paddr == IPLR_OFS_TIMER4_COMPARE3);
    wire logic hitAny = hitI2c || hitExt || hitTmr;
    wire logic accessPhase = psel && penable && pready;
    wire logic doWrite = accessPhase && pwrite;
    // low byte lane carries bits 7:0, next lane bits 15:8
    wire logic wrI2c = doWrite && hitI2c && pstrb[0];
    wire logic wrExt = doWrite && hitExt && pstrb[0];
    wire logic wrTmr = doWrite && hitTmr && pstrb[1];
    wire logic wrCmp = doWrite && hitTmr && pstrb[0];

    // ------------------------------------------------------------
    // field storage
    // ------------------------------------------------------------
    logic [2:0] i2cLevel;
    logic [2:0] extLevel;
    logic [2:0] tmrLevel;
    logic [2:0] cmpLevel;
    logic i2cOn;
    logic extOn;
    logic tmrOn;
    logic cmpOn;

    iplr_level_field uI2c (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .wrEn(wrI2c),
        .wrData(pwdata[IPLR_POS_I2C_TARGET +: IPLR_LEVEL_W]),
        .level(i2cLevel),
        .enabled(i2cOn)
    );

    iplr_level_field uExt (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .wrEn(wrExt),
        .wrData(pwdata[IPLR_POS_EXT_IRQ1 +: IPLR_LEVEL_W]), // [RQ4]
        .level(extLevel),
        .enabled(extOn)
    );

    iplr_level_field uTmr (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .wrEn(wrTmr),
        .wrData(pwdata[IPLR_POS_TIMER4 +: IPLR_LEVEL_W]), // [RQ5]
        .level(tmrLevel),
        .enabled(tmrOn)
    );

    iplr_level_field uCmp (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .wrEn(wrCmp),
        .wrData(pwdata[IPLR_POS_COMPARE3 +: IPLR_LEVEL_W]), // [RQ5]
        .level(cmpLevel),
        .enabled(cmpOn)
    );

    // ------------------------------------------------------------
    // read mux: only implemented fields placed, all else zero
    // ------------------------------------------------------------
    logic [31:0] rdI2c;
    logic [31:0] rdExt;
    logic [31:0] rdTmr;
    always_comb begin
        rdI2c = 32'h0000_0000;
        rdExt = 32'h0000_0000;
        rdTmr = 32'h0000_0000;
        rdI2c[IPLR_POS_I2C_TARGET +: IPLR_LEVEL_W] = i2cLevel;
        rdExt[IPLR_POS_EXT_IRQ1 +: IPLR_LEVEL_W] = extLevel; // [RQ3] [RQ4]
        rdTmr[IPLR_POS_TIMER4 +: IPLR_LEVEL_W] = tmrLevel;
        rdTmr[IPLR_POS_COMPARE3 +: IPLR_LEVEL_W] = cmpLevel; // [RQ5]
    end
    wire logic [31:0] rdSel = hitI2c ? rdI2c : hitExt ? rdExt : hitTmr ? rdTmr : 32'h0000_0000; // [RQ3]

    // ------------------------------------------------------------
    // apb answer: registered, no wait state after setup
    // ------------------------------------------------------------
    // pready rises the cycle after setup so prdata can come from a flop
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= setupPhase;
            prdata <= (setupPhase && !pwrite) ? rdSel : 32'h0000_0000;
            pslverr <= setupPhase && !hitAny;
        end
    end

    // ------------------------------------------------------------
    // registered level and enable outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            levels <= {4{IPLR_LEVEL_RESET}}; // [RQ6]
            enables <= 4'hf;
        end else begin
            levels <= '{i2cTargetEvent: i2cLevel, extIrq1: extLevel, timer4: tmrLevel, compare3: cmpLevel}; // [RQ1]
            enables <= '{i2cTargetEvent: i2cOn, extIrq1: extOn, timer4: tmrOn, compare3: cmpOn}; // [RQ2]
        end
    end
endmodule

// ### tb/iplr_regs_monitor.sv
// iplr_regs_monitor: assertions on the ports of the priority register bank
// assumes one apb access completes per pready pulse and levels lag writes by a cycle
`timescale 1ns/1ps
module iplr_regs_monitor (
    // clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // levels
    input wire iplr_pkg::iplr_levels_t levels,
    input wire iplr_pkg::iplr_enables_t enables
);
    import iplr_pkg::*;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    wire wrDone = psel && penable && pready && pwrite;
    wire rdExt = psel && penable && pready && !pwrite && paddr == IPLR_OFS_EXT_IRQ1;
    wire wrCmp = wrDone && paddr == IPLR_OFS_TIMER4_COMPARE3;
    reset_level_a: assert property ($rose(nrst) |-> levels == 12'h924) else $error("bad reset level");
    zero_off_a: assert property (enables == {|levels.i2cTargetEvent, |levels.extIrq1, |levels.timer4,
        |levels.compare3}) else $error("enable mismatch");
    rd_unimpl_a: assert property (rdExt |-> prdata[31:3] == 29'h0) else $error("upper bits set");
    rd_level_a: assert property (rdExt |-> prdata[2:0] == levels.extIrq1) else $error("read level");
    ext_write_a: assert property (wrDone && paddr == IPLR_OFS_EXT_IRQ1 && pstrb[0] |->
        ##2 levels.extIrq1 == $past(pwdata[2:0], 2)) else $error("ext level");
    tmr_write_a: assert property (wrCmp && pstrb[1] |-> ##2 levels.timer4 == $past(pwdata[14:12], 2))
        else $error("timer level");
    cmp_write_a: assert property (wrCmp && pstrb[0] |-> ##2 levels.compare3 == $past(pwdata[6:4], 2))
        else $error("compare level");
    // answer timing: one wait-free access phase, ready for a single cycle; unmapped writes leave levels unchanged
    ready_setup_a: assert property (psel && !penable |=> pready) else $error("no ready after setup");
    ready_pulse_a: assert property (pready |=> !pready) else $error("ready held too long");
    rd_idle_a: assert property (!pready |-> prdata == 32'h0000_0000) else $error("read data outside access");
    err_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
    unmapped_write_a: assert property (wrDone && pslverr |-> ##1 $stable(levels)) else $error("unmapped write landed");
endmodule
bind iplr_regs iplr_regs_monitor mon (.*);

// ### tb/testbench.sv
// testbench: apb register tests of the priority register bank
// assumes the design answers each access within a few cycles
`timescale 1ns/1ps
module testbench;
    import iplr_pkg::*;
    logic clk_sys = 1'h0, nrst = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0] pstrb = 4'h0;
    logic pready, pslverr, err;
    iplr_levels_t levels;
    iplr_enables_t enables;
    int num_errors = 0, checks = 0, cyc = 0;
    iplr_regs dut (.*);
    always #25 clk_sys = ~clk_sys;
    task automatic finish_test();
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one transfer; an idle cycle follows so no strobe is driven twice at one edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk_sys);
        penable <= 1'h1;
        do @(posedge clk_sys); while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge clk_sys);
    endtask
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 2000) begin
            num_errors++;
            finish_test();
        end
    end
    initial begin
        repeat (20) @(posedge clk_sys);
        nrst <= 1'h1;
        @(posedge clk_sys);
        chk("levels", 32'h924, 32'(levels));
        chk("enables", 32'hf, 32'(enables));
        apb(1'h0, IPLR_OFS_TIMER4_COMPARE3, 32'h0, 4'h0);
        chk("t4 oc3 reset", 32'h4040, rd);
        chk("mapped err", 32'h0, 32'(err));
        for (int c = 0; c < 8; c++) begin
            apb(1'h1, IPLR_OFS_EXT_IRQ1, {29'h1fffffff, 3'(c)}, 4'hf);
            apb(1'h0, IPLR_OFS_EXT_IRQ1, 32'h0, 4'h0);
            chk("ext read", 32'(c), rd);
            chk("ext level", 32'(c), 32'(levels.extIrq1));
            chk("ext enable", 32'(c != 0), 32'(enables.extIrq1));
        end
        apb(1'h1, IPLR_OFS_TIMER4_COMPARE3, 32'hffffffff, 4'hf);
        apb(1'h0, IPLR_OFS_TIMER4_COMPARE3, 32'h0, 4'h0);
        chk("t4 oc3 ones", 32'h7070, rd);
        apb(1'h1, IPLR_OFS_I2C_EVENTS, 32'hffffffff, 4'hf);
        apb(1'h0, IPLR_OFS_I2C_EVENTS, 32'h0, 4'h0);
        chk("i2c ones", 32'h7, rd);
        apb(1'h1, IPLR_OFS_TIMER4_COMPARE3, 32'h0, 4'h1);
        apb(1'h1, IPLR_OFS_I2C_EVENTS, 32'h0, 4'hf);
        apb(1'h0, IPLR_OFS_TIMER4_COMPARE3, 32'h0, 4'h0);
        chk("lane0 only", 32'h7000, rd);
        chk("enables", 32'h6, 32'(enables));
        chk("levels mixed", 32'h1f8, 32'(levels));
        apb(1'h1, 12'h00c, 32'hffffffff, 4'hf);
        chk("unmapped wr err", 32'h1, 32'(err));
        chk("levels unmapped wr", 32'h1f8, 32'(levels));
        apb(1'h0, 12'h00c, 32'h0, 4'h0);
        chk("unmapped err", 32'h1, 32'(err));
        chk("unmapped data", 32'h0, rd);
        nrst <= 1'h0;
        repeat (2) @(posedge clk_sys);
        nrst <= 1'h1;
        @(posedge clk_sys);
        chk("levels", 32'h924, 32'(levels));
        finish_test();
    end
endmodule
